// *** inc/gpd_pkg.sv ***
// Constants, types and register map of the GPIO drive control block.
// Assumes a plain one-cycle register port and a single 10 MHz clock.
package gpd_pkg;

    // ======================================================================
    // Register offsets
    localparam logic [7:0] OFS_A_LEVEL = 8'h00;
    localparam logic [7:0] OFS_B_LEVEL = 8'h01;
    localparam logic [7:0] OFS_A_SEL_LO = 8'h0A;
    localparam logic [7:0] OFS_A_SEL_HI = 8'h0B;
    localparam logic [7:0] OFS_B_SEL_LO = 8'h0C;
    localparam logic [7:0] OFS_B_SEL_HI = 8'h0D;
    localparam logic [7:0] OFS_IRQ_SEL_A = 8'h10;
    localparam logic [7:0] OFS_IRQ_SEL_B = 8'h11;
    localparam logic [7:0] OFS_IRQ_STAT_A = 8'h12;
    localparam logic [7:0] OFS_IRQ_STAT_B = 8'h13;

    // ======================================================================
    // Widths and reset values
    localparam int PINS_A = 8;
    localparam int PINS_B = 2;
    localparam int PINS = 10;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [PINS-1:0] RST_PINS = 10'h000;
    // Cycles after reset before the synchroniser and the previous level hold real pin levels.
    localparam logic [1:0] WARM_DONE = 2'h3;

    // ======================================================================
    // Sink strength codes
    localparam logic [1:0] SINK_OFF = 2'h0;
    localparam logic [1:0] SINK_LOW = 2'h1;
    localparam logic [1:0] SINK_MED = 2'h2;
    localparam logic [1:0] SINK_HIGH = 2'h3;

    typedef struct packed {
        logic pullup_en;
        logic source_en;
        logic sink_en;
        logic [1:0] sink_strength;
        logic ttl_sel;
    } gpd_drive_s;

    typedef struct packed {
        logic [PINS-1:0] level;
        logic [PINS-1:0] sel_lo;
        logic [PINS-1:0] sel_hi;
        logic [PINS-1:0] irq_sel;
        logic [PINS-1:0] irq_stat;
        logic [PINS-1:0] sync1;
        logic [PINS-1:0] sync2;
        logic [PINS-1:0] prev;
        logic [1:0] warm;
        logic [7:0] rdata;
        logic irq;
        gpd_drive_s [PINS-1:0] drive;
    } gpd_state_s;

endpackage

// *** rtl/gpd_top.sv ***
// GPIO drive control: ten pins (port A eight, port B two), data and
// drive-select registers, live pin read-back and per-pin interrupts.
// Assumes a register master on clk and pins from outside the clock domain.
// Operation
// - A data register write stores the outgoing level of each pin.
// - A data register read returns the synchronised pin levels.
// - Each pin decodes its drive from its own data and select bits.
// - Port A has pins 7..0; port B has pins 1..0, bits 7..2 reserved.
// - Reset clears all data and select registers, leaving pins undriven.
// - Both select bits zero leaves the pin undriven whatever the data.
// - Undriven pins pick TTL threshold on data 1, CMOS otherwise.
// - Select hi 1, lo 0, data 0 enables the sink at weakest strength.
// - Select hi 0, lo 1, data 0 enables the sink at medium strength.
// - Both selects 1 with data 0 enables the sink at strongest strength.
// - Select lo 1 with data 1 enables only the source device.
// - Select hi 1, lo 0, data 1 enables only the resistive pull-up.
// - Each pin can be chosen as an interrupt source.
// - Drive-select registers are write-only, port B using bits 1..0.
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
module gpd_top (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // Pins
    input wire logic [gpd_pkg::PINS-1:0] pin_in,
    output gpd_pkg::gpd_drive_s [gpd_pkg::PINS-1:0] drive,
    // Interrupt
    output logic irq
);

    // ======================================================================
    // State
    gpd_pkg::gpd_state_s st_r;
    gpd_pkg::gpd_state_s st_nxt;

    // ======================================================================
    // Per-pin drive decoder
    // Every case sets all fields, so no device can stay enabled by default;
    // at most one of the pull-up, source and sink enables is ever set.
    function automatic gpd_pkg::gpd_drive_s decode(
        input logic data,
        input logic lo,
        input logic hi
    );
        gpd_pkg::gpd_drive_s d;
        d = '0;
        unique case ({hi, lo, data})
            3'b000: begin
                d.pullup_en = 1'b0;
                d.source_en = 1'b0;
                d.sink_en = 1'b0;
                d.sink_strength = gpd_pkg::SINK_OFF;
                d.ttl_sel = 1'b0;
            end

            3'b001: begin
                d.pullup_en = 1'b0;
                d.source_en = 1'b0;
                d.sink_en = 1'b0;
                d.sink_strength = gpd_pkg::SINK_OFF;
                d.ttl_sel = 1'b1;
            end

            3'b100: begin
                d.pullup_en = 1'b0;
                d.source_en = 1'b0;
                d.sink_en = 1'b1;
                d.sink_strength = gpd_pkg::SINK_LOW;
                d.ttl_sel = 1'b0;
            end

            3'b010: begin
                d.pullup_en = 1'b0;
                d.source_en = 1'b0;
                d.sink_en = 1'b1;
                d.sink_strength = gpd_pkg::SINK_MED;
                d.ttl_sel = 1'b0;
            end

            3'b110: begin
                d.pullup_en = 1'b0;
                d.source_en = 1'b0;
                d.sink_en = 1'b1;
                d.sink_strength = gpd_pkg::SINK_HIGH;
                d.ttl_sel = 1'b0;
            end

            3'b011: begin
                d.pullup_en = 1'b0;
                d.source_en = 1'b1;
                d.sink_en = 1'b0;
                d.sink_strength = gpd_pkg::SINK_OFF;
                d.ttl_sel = 1'b0;
            end

            3'b111: begin
                d.pullup_en = 1'b0;
                d.source_en = 1'b1;
                d.sink_en = 1'b0;
                d.sink_strength = gpd_pkg::SINK_OFF;
                d.ttl_sel = 1'b0;
            end

            3'b101: begin
                d.pullup_en = 1'b1;
                d.source_en = 1'b0;
                d.sink_en = 1'b0;
                d.sink_strength = gpd_pkg::SINK_OFF;
                d.ttl_sel = 1'b0;
            end
        endcase
        return d;
    endfunction

    // Both ports share one decoder; port B simply starts at pin 8.
    function automatic gpd_pkg::gpd_drive_s [gpd_pkg::PINS-1:0] decode_all(
        input logic [gpd_pkg::PINS-1:0] level,
        input logic [gpd_pkg::PINS-1:0] lo,
        input logic [gpd_pkg::PINS-1:0] hi
    );
        gpd_pkg::gpd_drive_s [gpd_pkg::PINS-1:0] v;
        v = '0;
        for (int i = 0; i < gpd_pkg::PINS_A; i++) begin
            v[i] = decode(level[i], lo[i], hi[i]);
        end
        for (int i = gpd_pkg::PINS_A; i < gpd_pkg::PINS; i++) begin
            v[i] = decode(level[i], lo[i], hi[i]);
        end
        return v;
    endfunction

    // ======================================================================
    // Port slicing
    // Port A sits in bits 7..0 of every pin vector, port B in bits 9..8.
    function automatic logic [7:0] port_a(
        input logic [gpd_pkg::PINS-1:0] v
    );
        return v[7:0];
    endfunction

    // Bits 7..2 of port B do not exist and read as zero.
    function automatic logic [7:0] port_b(
        input logic [gpd_pkg::PINS-1:0] v
    );
        return {6'h00, v[9:8]};
    endfunction

    function automatic logic [gpd_pkg::PINS-1:0] put_a(
        input logic [gpd_pkg::PINS-1:0] v,
        input logic [7:0] b
    );
        return {v[9:8], b};
    endfunction

    // Bits 7..2 of a port B write are reserved and dropped.
    function automatic logic [gpd_pkg::PINS-1:0] put_b(
        input logic [gpd_pkg::PINS-1:0] v,
        input logic [7:0] b
    );
        return {b[1:0], v[7:0]};
    endfunction

    function automatic logic [gpd_pkg::PINS-1:0] clr_a(
        input logic [gpd_pkg::PINS-1:0] v
    );
        return {v[9:8], 8'h00};
    endfunction

    function automatic logic [gpd_pkg::PINS-1:0] clr_b(
        input logic [gpd_pkg::PINS-1:0] v
    );
        return {2'h0, v[7:0]};
    endfunction

    // ======================================================================
    // Pin events and interrupt
    // An event is any level change of a synchronised pin. The synchroniser
    // and the previous level clear to zero, so events are held off until
    // both hold real pin levels; a pin idling high gives no false event.
    // The warm-up counter saturates; it gates events only, never the port.
    // A change during the first cycle after reset is not reported.
    function automatic logic [1:0] warm_step(
        input logic [1:0] w
    );
        logic [1:0] n;
        n = w;
        if (w != gpd_pkg::WARM_DONE) begin
            n = w + 2'h1;
        end
        return n;
    endfunction

    function automatic logic [gpd_pkg::PINS-1:0] pin_events(
        input logic [gpd_pkg::PINS-1:0] cur,
        input logic [gpd_pkg::PINS-1:0] old,
        input logic ready
    );
        return ready ? (cur ^ old) : gpd_pkg::RST_PINS;
    endfunction

    // Setting wins over a clearing read in the same cycle, so an event that
    // lands beside the read is kept for the next one.
    function automatic logic [gpd_pkg::PINS-1:0] stat_next(
        input logic [gpd_pkg::PINS-1:0] stat,
        input logic rd_stb,
        input logic [7:0] a,
        input logic [gpd_pkg::PINS-1:0] ev
    );
        logic [gpd_pkg::PINS-1:0] n;
        n = stat;
        if (rd_stb && a == gpd_pkg::OFS_IRQ_STAT_A) begin
            n = clr_a(stat);
        end
        if (rd_stb && a == gpd_pkg::OFS_IRQ_STAT_B) begin
            n = clr_b(stat);
        end
        return n | ev;
    endfunction

    function automatic logic irq_next(
        input logic [gpd_pkg::PINS-1:0] stat,
        input logic [gpd_pkg::PINS-1:0] sel
    );
        return |(stat & sel);
    endfunction

    // ======================================================================
    // Read multiplexer
    function automatic logic [7:0] read_mux(
        input logic [7:0] a,
        input gpd_pkg::gpd_state_s s
    );
        logic [7:0] r;
        r = gpd_pkg::RST_BYTE;
        unique case (a)
            gpd_pkg::OFS_A_LEVEL: begin
                r = port_a(s.sync2);
            end
            gpd_pkg::OFS_B_LEVEL: begin
                r = port_b(s.sync2);
            end

            gpd_pkg::OFS_A_SEL_LO: begin
                r = gpd_pkg::RST_BYTE;
            end
            gpd_pkg::OFS_A_SEL_HI: begin
                r = gpd_pkg::RST_BYTE;
            end
            gpd_pkg::OFS_B_SEL_LO: begin
                r = gpd_pkg::RST_BYTE;
            end
            gpd_pkg::OFS_B_SEL_HI: begin
                r = gpd_pkg::RST_BYTE;
            end

            gpd_pkg::OFS_IRQ_SEL_A: begin
                r = port_a(s.irq_sel);
            end
            gpd_pkg::OFS_IRQ_SEL_B: begin
                r = port_b(s.irq_sel);
            end

            gpd_pkg::OFS_IRQ_STAT_A: begin
                r = port_a(s.irq_stat);
            end
            gpd_pkg::OFS_IRQ_STAT_B: begin
                r = port_b(s.irq_stat);
            end

            default: begin
                r = gpd_pkg::RST_BYTE;
            end
        endcase
        return r;
    endfunction

    // ======================================================================
    // Register writes
    // Writes to unmapped offsets leave every register as it was, and the
    // status registers change only through events and clearing reads.
    function automatic gpd_pkg::gpd_state_s write_regs(
        input gpd_pkg::gpd_state_s s,
        input logic [7:0] a,
        input logic [7:0] d
    );
        gpd_pkg::gpd_state_s n;
        n = s;
        unique case (a)
            gpd_pkg::OFS_A_LEVEL: begin
                n.level = put_a(s.level, d);
            end
            gpd_pkg::OFS_B_LEVEL: begin
                n.level = put_b(s.level, d);
            end

            gpd_pkg::OFS_A_SEL_LO: begin
                n.sel_lo = put_a(s.sel_lo, d);
            end
            gpd_pkg::OFS_A_SEL_HI: begin
                n.sel_hi = put_a(s.sel_hi, d);
            end
            gpd_pkg::OFS_B_SEL_LO: begin
                n.sel_lo = put_b(s.sel_lo, d);
            end
            gpd_pkg::OFS_B_SEL_HI: begin
                n.sel_hi = put_b(s.sel_hi, d);
            end

            gpd_pkg::OFS_IRQ_SEL_A: begin
                n.irq_sel = put_a(s.irq_sel, d);
            end
            gpd_pkg::OFS_IRQ_SEL_B: begin
                n.irq_sel = put_b(s.irq_sel, d);
            end

            default: begin
                n = s;
            end
        endcase
        return n;
    endfunction

    // ======================================================================
    // Next state
    always_comb begin
        st_nxt = st_r;
        if (wr) begin
            st_nxt = write_regs(st_r, addr, wdata);
        end
        // Two-flop synchroniser; only its second stage feeds any logic.
        st_nxt.sync1 = pin_in;
        st_nxt.sync2 = st_r.sync1;
        st_nxt.prev = st_r.sync2;
        st_nxt.warm = warm_step(st_r.warm);
        st_nxt.rdata = gpd_pkg::RST_BYTE;
        if (rd) begin
            st_nxt.rdata = read_mux(addr, st_r);
        end
        // A pin change reaches the status three edges after it appears on
        // the pin: two synchroniser stages, then the compare with the
        // previous level.
        st_nxt.irq_stat = stat_next(st_r.irq_stat, rd, addr,
            pin_events(st_r.sync2, st_r.prev,
                       st_r.warm == gpd_pkg::WARM_DONE));
        st_nxt.irq = irq_next(st_nxt.irq_stat, st_r.irq_sel);
        // The drive follows the values being written, so a write reaches
        // the pin devices at the same edge that stores it.
        st_nxt.drive = decode_all(st_nxt.level, st_nxt.sel_lo,
                                  st_nxt.sel_hi);
    end

    // ======================================================================
    // State register
    // The reset branch loads constants only.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ======================================================================
    // Outputs, each straight from the state register
    assign rdata = st_r.rdata;
    assign drive = st_r.drive;
    assign irq = st_r.irq;

endmodule // gpd_top

// *** bench/gpd_properties.sv ***
// Checker of the GPIO drive block, seeing only the top ports.
// Assumes it is bound to gpd_top from the testbench top file.
`timescale 1ns/1ps
module gpd_properties (
    // Watched ports
    input wire logic clk,
    input wire logic resetn,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    input wire logic [gpd_pkg::PINS-1:0] pin_in,
    input wire gpd_pkg::gpd_drive_s [gpd_pkg::PINS-1:0] drive,
    input wire logic irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // ==========================================================
    // Register port and pin decode
    rd_idle_a: assert property (!$past(rd) |-> rdata == 8'h00)
        else $error("rdata not idle");
    sel_read_a: assert property (
        rd && addr == 8'h0B |=> rdata == 8'h00) else $error("select read");
    b_resv_a: assert property (
        rd && addr == 8'h01 |=> rdata[7:2] == 6'h00)
        else $error("port b reserved");
    pin_read_a: assert property (
        $stable(pin_in) [*3] ##0 rd && addr == 8'h00
        |=> rdata == $past(pin_in[7:0])) else $error("pin read");
    one_hot_a: assert property (
        $onehot0(drive[0][5:3]) && $onehot0(drive[9][5:3]))
        else $error("devices");
    ttl_a: assert property (drive[0].ttl_sel |-> drive[0][5:3] == 3'h0)
        else $error("threshold");
    rst_a: assert property ($rose(resetn) |-> drive == '0)
        else $error("reset drive");
    hz_a: assert property (
        wr && addr == 8'h0A && wdata == 8'h00 ##2 wr && addr == 8'h0B
        && wdata == 8'h00 |=> drive[0][5:3] == 3'h0) else $error("hi-z");
    cover property ($rose(irq));
    cover property (drive[0].sink_en);
    cover property (rd && addr == 8'h12);
endmodule // gpd_properties

// *** bench/gpd_board.sv ***
// Board model: an outside level on each pin, overridden by the drive.
// Assumes one gpd_drive_s per pin; a sink beats any outside level.
`timescale 1ns/1ps
module gpd_board (
    // Block drive, outside levels and pins
    input wire gpd_pkg::gpd_drive_s [gpd_pkg::PINS-1:0] drive,
    input wire logic [gpd_pkg::PINS-1:0] ext,
    output logic [gpd_pkg::PINS-1:0] pin_in
);
    always_comb begin
        for (int i = 0; i < gpd_pkg::PINS; i++) begin
            if (drive[i].sink_en) pin_in[i] = 1'b0;
            else if (drive[i][5:4] != 2'h0) pin_in[i] = 1'b1;
            else pin_in[i] = ext[i];
        end
    end
endmodule // gpd_board

// *** bench/tb.sv ***
// Testbench of the GPIO drive block with the board model.
// Assumes the register port of gpd_top and a 10 MHz clock.
`timescale 1ns/1ps
module tb;
    logic clk = 1'b0, resetn = 1'b0, wr = 1'b0, rd = 1'b0, irq;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
    logic [9:0] ext = 10'h000, pin_in;
    gpd_pkg::gpd_drive_s [9:0] drive;
    int n_fail = 0, comparisons = 0;
    gpd_top i_gpd_top (.clk, .resetn, .addr, .wdata, .wr, .rd, .rdata,
        .pin_in, .drive, .irq);
    gpd_board i_gpd_board (.drive, .ext, .pin_in);
    // ==========================================================
    // Tasks
    task automatic chk(input logic [11:0] e, input logic [11:0] g);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED port exp %h got %h", e, g);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk({4'h0, e}, {4'h0, rdata});
    endtask
    // Expected drive of one pin from {data, select hi, select lo}.
    function automatic logic [5:0] dec(input logic [2:0] v);
        logic s;
        s = ~v[2] & (v[1] | v[0]);
        return {v[1] & ~v[0] & v[2], v[0] & v[2], s,
            s ? {v[0], v[1]} : 2'h0, v[2] & ~v[1] & ~v[0]};
    endfunction
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // ==========================================================
    // Stimulus
    initial forever #50 clk = ~clk;
    initial begin
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        #1 chk(12'h000, drive[1:0]);
        rreg(8'h0A, 8'h00);
        for (int k = 0; k < 8; k++) begin
            wreg(8'h00, {6'h00, ~k[2], k[2]});
            wreg(8'h0A, {6'h00, ~k[0], k[0]});
            wreg(8'h0B, {6'h00, ~k[1], k[1]});
            #1 chk({dec(~k[2:0]), dec(k[2:0])}, drive[1:0]);
        end
        $display("decode test done");
        wreg(8'h0A, 8'h00);
        wreg(8'h0B, 8'h00);
        @(posedge clk);
        ext <= 10'h3A5;
        repeat (3) @(posedge clk);
        rreg(8'h00, 8'hA5);
        rreg(8'h01, 8'h03);
        rreg(8'hFF, 8'h00);
        chk(12'h000, {11'h0, irq});
        rreg(8'h12, 8'hA7);
        rreg(8'h13, 8'h03);
        $display("read test done");
        wreg(8'h10, 8'h04);
        ext <= 10'h3A1;
        repeat (4) @(posedge clk);
        #1 chk(12'h001, {11'h0, irq});
        rreg(8'h12, 8'h04);
        @(posedge clk);
        #1 chk(12'h000, {11'h0, irq});
        $display("interrupt test done");
        wreg(8'h0A, 8'h20);
        repeat (2) @(posedge clk);
        #1 chk(12'h00C, {6'h00, drive[5]});
        rreg(8'h00, 8'h81);
        wreg(8'h0A, 8'h00);
        repeat (2) @(posedge clk);
        rreg(8'h00, 8'hA1);
        $display("open drain test done");
        print_verdict;
    end
    initial begin
        repeat (3000) @(posedge clk);
        n_fail++;
        print_verdict;
    end
endmodule // tb
bind gpd_top gpd_properties i_gpd_properties (.clk, .resetn, .addr,
    .wdata, .wr, .rd, .rdata, .pin_in, .drive, .irq);
